// ==== rmc_radio_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none

module rmc_radio_mode_controller
  import rmc_pkg::*;
(
  input  wire logic       clk_i,
  input  wire logic       reset_i,
  input  wire logic       power_up_bit_i,
  input  wire logic       receive_role_select_i,
  input  wire logic       chip_enable_i,
  input  wire logic       spi_select_n_i,
  input  wire logic       tx_fifo_empty_i,
  input  wire logic       tx_packet_done_i,
  input  wire logic       rx_packet_end_i,
  input  wire logic       rx_address_match_i,
  input  wire logic       rx_crc_valid_i,
  input  wire logic       rx_fifo_full_i,
  input  wire logic       power_detect_raw_i,
  input  wire logic [1:0] air_rate_select_i,
  output logic [2:0]      mode_o,
  output logic            synth_on_o,
  output logic            clock_buffers_on_o,
  output logic            tx_active_o,
  output logic            rx_active_o,
  output logic            tx_start_o,
  output logic            rx_accept_o,
  output logic            rx_discard_o,
  output logic            received_power_flag_o,
  output logic [1:0]      air_rate_o
);

  rmc_state_type    state;
  rmc_state_type    next_state;
  logic [CNT_W-1:0] timer;
  logic [CNT_W-1:0] next_timer;
  logic [CNT_W-1:0] ce_count;
  logic [CNT_W-1:0] rpd_count;
  logic             ce_qualified;
  logic             tx_single_shot;
  logic             select_prev;
  logic             tx_start;
  logic             rx_accept;
  logic             rx_discard;
  logic             rpd_flag;
  logic [1:0]       air_rate;

  // Saturating increment shared by all counters
  function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 13'h0001;
  endfunction

  // Counter-reached test against a cycle count
  function automatic logic reached(input logic [CNT_W-1:0] v, input int n);
    reached = (int'(v) >= n - 1);
  endfunction

  // Decoded conditions
  wire rx_request     = power_up_bit_i & receive_role_select_i
                      & chip_enable_i;
  wire tx_role        = power_up_bit_i & ~receive_role_select_i;
  wire payload_ready  = ~tx_fifo_empty_i;
  wire ce_long        = chip_enable_i & reached(ce_count, CE_MIN_CYC);
  wire select_rise    = spi_select_n_i & ~select_prev;
  wire settle_done    = reached(timer, SB2A_CYC);
  wire pd_done        = reached(timer, PD2SB_CYC);
  wire rx_in_mode     = (state == RMC_RX);
  wire tx_from_standby = (state == RMC_STANDBY_1)
                      & (next_state == RMC_SETTLE_TX);
  wire rx_good        = rx_in_mode & rx_packet_end_i & rx_address_match_i
                      & rx_crc_valid_i;
  wire rate_legal     = (air_rate_select_i == AIR_RATE_1M)
                      | (air_rate_select_i == AIR_RATE_2M)
                      | (air_rate_select_i == AIR_RATE_250K);

  // Next mode and transition timer
  always_comb begin
    next_state = state;
    next_timer = sat_inc(timer);
    tx_start   = 1'b0;
    if (!power_up_bit_i) begin
      next_state = RMC_POWER_DOWN;
      next_timer = CNT_RESET;
    end else begin
      case (state)
        // Asleep: any power-up request starts the wake-up
        RMC_POWER_DOWN: begin
          next_state = RMC_PD_TO_STANDBY;
          next_timer = CNT_RESET;
        end
        // Oscillator already running, so the wake-up is short
        RMC_PD_TO_STANDBY: begin
          if (pd_done) begin
            next_state = RMC_STANDBY_1;
          end
        end
        // Receive wins over transmit when both are requested
        RMC_STANDBY_1: begin
          next_timer = CNT_RESET;
          if (rx_request) begin
            next_state = RMC_SETTLE_RX;
          end else if (tx_role && ce_qualified && payload_ready) begin
            next_state = RMC_SETTLE_TX;
          end else if (tx_role && chip_enable_i && !payload_ready
                       && ce_long) begin
            next_state = RMC_STANDBY_2;
          end
        end
        // Clock buffers stay on; a finished upload starts sending
        RMC_STANDBY_2: begin
          next_timer = CNT_RESET;
          if (!chip_enable_i || !tx_role) begin
            next_state = RMC_STANDBY_1;
          end else if (payload_ready && select_rise) begin
            next_state = RMC_SETTLE_TX;
          end
        end
        // Synthesizer settling; a dropped pulse still sends one packet
        RMC_SETTLE_TX: begin
          if (!tx_role) begin
            next_state = RMC_STANDBY_1;
          end else if (settle_done) begin
            next_state = RMC_TX;
            tx_start   = 1'b1;
          end
        end
        // Packet boundary decides: stop, turn round, repeat or wait
        RMC_TX: begin
          if (tx_packet_done_i) begin
            next_timer = CNT_RESET;
            if (!chip_enable_i || tx_single_shot) begin
              next_state = RMC_STANDBY_1;
            end else if (rx_request) begin
              next_state = RMC_SETTLE_RX;
            end else if (payload_ready) begin
              next_state = RMC_TX;
              tx_start   = 1'b1;
            end else begin
              next_state = RMC_STANDBY_2;
            end
          end
        end
        // Receive settling aborts if the request goes away
        RMC_SETTLE_RX: begin
          if (!rx_request) begin
            next_state = RMC_STANDBY_1;
          end else if (settle_done) begin
            next_state = RMC_RX;
          end
        end
        // Receive holds until chip-enable drops or the role flips
        RMC_RX: begin
          if (!chip_enable_i) begin
            next_state = RMC_STANDBY_1;
          end else if (!receive_role_select_i) begin
            next_state = RMC_SETTLE_TX;
            next_timer = CNT_RESET;
          end
        end
        default: begin
          next_state = RMC_POWER_DOWN;
          next_timer = CNT_RESET;
        end
      endcase
    end
  end

  // Mode register and timer
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      state <= RMC_POWER_DOWN;
      timer <= CNT_RESET;
    end else begin
      state <= next_state;
      timer <= next_timer;
    end
  end

  // Select history; resets high so an idle select gives no false edge
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      select_prev <= 1'b1;
    end else begin
      select_prev <= spi_select_n_i;
    end
  end

  // Chip-enable high time, saturating so a long hold never wraps to zero
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ce_count <= CNT_RESET;
    end else begin
      ce_count <= chip_enable_i ? sat_inc(ce_count) : CNT_RESET;
    end
  end

  // A qualified pulse is remembered in standby-I until a payload arrives
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ce_qualified <= 1'b0;
    end else if (ce_long) begin
      ce_qualified <= 1'b1;
    end else if (state != RMC_STANDBY_1) begin
      ce_qualified <= 1'b0;
    end
  end

  // Chip-enable already low on the move from standby-I to TX settling marks a one-packet pulse
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      tx_single_shot <= 1'b0;
    end else if (tx_from_standby) begin
      tx_single_shot <= ~chip_enable_i;
    end else if (state == RMC_STANDBY_2) begin
      tx_single_shot <= 1'b0;
    end
  end

  // Packet acceptance pulses; a full RX FIFO turns accept into discard
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rx_accept  <= 1'b0;
      rx_discard <= 1'b0;
    end else begin
      rx_accept  <= rx_good & ~rx_fifo_full_i;
      rx_discard <= rx_good & rx_fifo_full_i;
    end
  end

  // Detector persistence count; any dropout restarts the filter
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rpd_count <= CNT_RESET;
    end else if (rx_in_mode && power_detect_raw_i) begin
      rpd_count <= sat_inc(rpd_count);
    end else begin
      rpd_count <= CNT_RESET;
    end
  end

  // Received-power flag, held at its last value outside RX
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rpd_flag <= 1'b0;
    end else if (rx_in_mode) begin
      rpd_flag <= power_detect_raw_i
                & reached(rpd_count, RPD_CYC);
    end
  end

  // Air rate latch and status outputs
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      air_rate    <= AIR_RATE_RESET;
      mode_o      <= 3'h0;
      tx_start_o  <= 1'b0;
    end else begin
      if (rate_legal) begin
        air_rate <= air_rate_select_i;
      end
      mode_o     <= next_state;
      tx_start_o <= tx_start;
    end
  end

  // Output decoding
  assign synth_on_o            = (mode_o == 3'(RMC_SETTLE_TX))
                               | (mode_o == 3'(RMC_SETTLE_RX))
                               | (mode_o == 3'(RMC_TX))
                               | (mode_o == 3'(RMC_RX));
  assign clock_buffers_on_o    = (mode_o == 3'(RMC_STANDBY_2));
  assign tx_active_o           = (mode_o == 3'(RMC_TX));
  assign rx_active_o           = (mode_o == 3'(RMC_RX));
  assign rx_accept_o           = rx_accept;
  assign rx_discard_o          = rx_discard;
  assign received_power_flag_o = rpd_flag;
  assign air_rate_o            = air_rate;

endmodule // rmc_radio_mode_controller

`default_nettype wire

// ==== rmc_pkg.sv ====
package rmc_pkg;

  // Clock rate in MHz
  localparam int CLK_MHZ = 25;

  // Documented times in nanoseconds
  localparam int POWERDOWN_TO_STANDBY_TIME_NS  = 1000;
  localparam int STANDBY_TO_ACTIVE_TIME_NS     = 130000;
  localparam int ENABLE_MIN_HIGH_TIME_NS       = 10000;
  localparam int ENABLE_EDGE_TO_SELECT_DELAY_NS = 4000;
  localparam int POWER_PERSIST_TIME_NS         = 40000;
  localparam int TX_MAX_TIME_NS                = 4000000;

  // Cycle counts: longest times round down, least times round up
  localparam int PD2SB_CYC  = (POWERDOWN_TO_STANDBY_TIME_NS * CLK_MHZ) / 1000;
  localparam int SB2A_CYC   = (STANDBY_TO_ACTIVE_TIME_NS * CLK_MHZ) / 1000;
  localparam int CE_MIN_CYC = (ENABLE_MIN_HIGH_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int RPD_CYC    = (POWER_PERSIST_TIME_NS * CLK_MHZ + 999) / 1000;

  // Counter width and reset value
  localparam int CNT_W = 13;
  localparam logic [CNT_W-1:0] CNT_RESET = 13'h0000;

  // Air rate encodings
  localparam logic [1:0] AIR_RATE_1M   = 2'h0;
  localparam logic [1:0] AIR_RATE_2M   = 2'h1;
  localparam logic [1:0] AIR_RATE_250K = 2'h2;
  localparam logic [1:0] AIR_RATE_RESET = AIR_RATE_1M;

  // Operating modes
  typedef enum logic [2:0] {
    RMC_POWER_DOWN,
    RMC_PD_TO_STANDBY,
    RMC_STANDBY_1,
    RMC_STANDBY_2,
    RMC_SETTLE_TX,
    RMC_TX,
    RMC_SETTLE_RX,
    RMC_RX
  } rmc_state_type;

endpackage

// ==== rmc_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
// Port checks on mode sequencing, mode timing and receive pulses
module rmc_monitor (
  input wire logic       clk_i,
  input wire logic       reset_i,
  input wire logic       power_up_bit_i,
  input wire logic       receive_role_select_i,
  input wire logic       chip_enable_i,
  input wire logic       spi_select_n_i,
  input wire logic       tx_fifo_empty_i,
  input wire logic       tx_packet_done_i,
  input wire logic       rx_packet_end_i,
  input wire logic       rx_address_match_i,
  input wire logic       rx_crc_valid_i,
  input wire logic       rx_fifo_full_i,
  input wire logic       power_detect_raw_i,
  input wire logic [2:0] mode_o,
  input wire logic       rx_accept_o,
  input wire logic       received_power_flag_o
);
  logic [2:0]  prev;
  logic [12:0] stay;
  logic [10:0] raw;
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Cycles in the present mode, and of steady detect while in RX
  always_ff @(posedge clk_i) begin
    prev <= mode_o;
    stay <= (reset_i || mode_o != prev) ? 13'h0000 : stay + 13'h0001;
    raw  <= (power_detect_raw_i && mode_o == 3'h7) ? raw + 11'h001 : 11'h000;
  end
  reset_mode_a:
    assert property ($fell(reset_i) |-> mode_o == 3'h0)
    else $error("not in power-down after reset");
  pd_entry_a:
    assert property (!power_up_bit_i |=> mode_o == 3'h0)
    else $error("power-up low did not power down");
  wake_time_a:
    assert property (mode_o == 3'h1 && prev == 3'h1 |-> stay <= 13'h0018)
    else $error("wake-up too slow");
  settle_time_a:
    assert property (mode_o[2] && !mode_o[0] && prev == mode_o |-> stay <= 13'h0CB1)
    else $error("settling too slow");
  rx_leave_a:
    assert property (mode_o == 3'h7 && !chip_enable_i |=> mode_o inside {3'h0, 3'h2})
    else $error("receive kept without chip-enable");
  tx_done_a:
    assert property (mode_o == 3'h5 && tx_packet_done_i && power_up_bit_i &&
      !receive_role_select_i |=> mode_o == (!$past(chip_enable_i) ? 3'h2 :
      $past(tx_fifo_empty_i) ? 3'h3 : 3'h5))
    else $error("wrong mode after packet sent");
  rx_accept_a:
    assert property (rx_packet_end_i && mode_o == 3'h7 |=> rx_accept_o ==
      $past(rx_address_match_i && rx_crc_valid_i && !rx_fifo_full_i))
    else $error("packet acceptance wrong");
  sb2_hold_a:
    assert property (mode_o == 3'h3 && !spi_select_n_i |=> mode_o != 3'h4)
    else $error("transmit began before select rose");
  rpd_delay_a:
    assert property ($rose(received_power_flag_o) |-> raw >= 11'h3E7)
    else $error("power flag rose too early");
endmodule // rmc_monitor

bind rmc_radio_mode_controller rmc_monitor rmc_monitor_i (.*);
`default_nettype wire

// ==== rmc_host_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// Host side: control bits, select line and TX FIFO fill state
module rmc_host_model (
  input  wire logic  clk_i,
  output logic       power_up_bit_o,
  output logic       receive_role_select_o,
  output logic       chip_enable_o,
  output logic       spi_select_n_o,
  output logic       tx_fifo_empty_o,
  output logic [1:0] air_rate_select_o
);
  // Idle host: radio off, deselected, nothing queued
  initial begin
    {power_up_bit_o, receive_role_select_o, chip_enable_o} = 3'h0;
    {spi_select_n_o, tx_fifo_empty_o, air_rate_select_o} = 4'hC;
  end
  // Full configuration before any TX or RX request
  task automatic config_bits(input logic pu, rx, input logic [1:0] rate);
    @(negedge clk_i);
    power_up_bit_o = pu;
    receive_role_select_o = rx;
    air_rate_select_o = rate;
  endtask
  // Chip-enable as a level or as a timed pulse
  task automatic set_ce(input logic ce);
    @(negedge clk_i) chip_enable_o = ce;
  endtask
  task automatic pulse_ce(input int n);
    set_ce(1'b1);
    repeat (n) @(negedge clk_i);
    chip_enable_o = 1'b0;
  endtask
  // Payload upload: FIFO fills while selected, select rises at the end
  task automatic upload();
    @(negedge clk_i) spi_select_n_o = 1'b0;
    repeat (4) @(negedge clk_i);
    tx_fifo_empty_o = 1'b0;
    repeat (4) @(negedge clk_i);
    spi_select_n_o = 1'b1;
  endtask
  task automatic drain();
    @(negedge clk_i) tx_fifo_empty_o = 1'b1;
  endtask
endmodule // rmc_host_model
`default_nettype wire

// ==== test_radio_mode_controller.sv ====
`timescale 1ns/1ps
`default_nettype none
// Walks the radio through power-down, standby, TX and RX
module test_radio_mode_controller;
  logic       clk_i, reset_i, power_up_bit_i, receive_role_select_i;
  logic       chip_enable_i, spi_select_n_i, tx_fifo_empty_i;
  logic       tx_packet_done_i, rx_packet_end_i, rx_address_match_i;
  logic       rx_crc_valid_i, rx_fifo_full_i, power_detect_raw_i;
  logic       synth_on_o, clock_buffers_on_o, tx_active_o, rx_active_o;
  logic       tx_start_o, rx_accept_o, rx_discard_o, received_power_flag_o;
  logic [1:0] air_rate_select_i, air_rate_o;
  logic [2:0] mode_o;
  int         n_errors = 0;
  int         checks_done = 0;
  int         cyc = 0;
  rmc_radio_mode_controller rmc_radio_mode_controller_i (.*);
  rmc_host_model rmc_host_model_i (
    .clk_i                 (clk_i),
    .power_up_bit_o        (power_up_bit_i),
    .receive_role_select_o (receive_role_select_i),
    .chip_enable_o         (chip_enable_i),
    .spi_select_n_o        (spi_select_n_i),
    .tx_fifo_empty_o       (tx_fifo_empty_i),
    .air_rate_select_o     (air_rate_select_i)
  );
  // 25 MHz clock and a ceiling against a hang
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      complete_run();
    end
  end
  task automatic chk(input string what, input logic [2:0] exp, got);
    checks_done++;
    if (got !== exp)
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    if (got !== exp)
      n_errors++;
  endtask
  task automatic wait_mode(input logic [2:0] m, input int lim);
    for (int i = 0; i < lim && mode_o !== m; i++) @(negedge clk_i);
    chk("mode", m, mode_o);
  endtask
  // Radio reports a packet sent; TX stretches stay short
  task automatic tx_done();
    @(negedge clk_i) tx_packet_done_i = 1'b1;
    @(negedge clk_i) tx_packet_done_i = 1'b0;
  endtask
  task automatic rx_pkt(input logic [2:0] in, input logic [1:0] exp);
    @(negedge clk_i) rx_packet_end_i = 1'b1;
    {rx_address_match_i, rx_crc_valid_i, rx_fifo_full_i} = in;
    @(negedge clk_i) rx_packet_end_i = 1'b0;
    chk("rx pulses", {1'b0, exp}, {1'b0, rx_accept_o, rx_discard_o});
  endtask
  // Raw detector held at one level for a number of cycles
  task automatic rpd_drive(input logic lvl, input int n);
    power_detect_raw_i = lvl;
    repeat (n) @(negedge clk_i);
  endtask
  task automatic complete_run();
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    {tx_packet_done_i, rx_packet_end_i, rx_address_match_i} = 3'h0;
    {rx_crc_valid_i, rx_fifo_full_i, power_detect_raw_i, reset_i} = 4'h1;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    reset_i = 1'b0;
    chk("reset", 3'h0, mode_o);
    rmc_host_model_i.config_bits(1'b1, 1'b0, 2'h0);
    wait_mode(3'h2, 30);
    for (int r = 0; r < 4; r++) begin
      rmc_host_model_i.config_bits(1'b1, 1'b0, r[1:0]);
      repeat (2) @(negedge clk_i);
      chk("rate", (r == 3) ? 3'h2 : r[2:0], {1'b0, air_rate_o});
    end
    rmc_host_model_i.upload();
    rmc_host_model_i.pulse_ce(100);
    repeat (4) @(negedge clk_i);
    chk("short ce", 3'h2, mode_o);
    rmc_host_model_i.pulse_ce(260);
    wait_mode(3'h5, 3600);
    chk("tx start", 3'h1, {2'h0, tx_start_o});
    chk("tx active", 3'h1, {2'h0, tx_active_o});
    rmc_host_model_i.drain();
    tx_done();
    chk("one shot", 3'h2, mode_o);
    rmc_host_model_i.upload();
    rmc_host_model_i.set_ce(1'b1);
    wait_mode(3'h5, 3600);
    tx_done();
    chk("refill", 3'h5, mode_o);
    chk("next start", 3'h1, {2'h0, tx_start_o});
    rmc_host_model_i.drain();
    tx_done();
    chk("standby2", 3'h3, mode_o);
    chk("synth", 3'h0, {2'h0, synth_on_o});
    chk("buffers", 3'h1, {2'h0, clock_buffers_on_o});
    rmc_host_model_i.upload();
    wait_mode(3'h4, 4);
    wait_mode(3'h5, 3300);
    rmc_host_model_i.drain();
    tx_done();
    rmc_host_model_i.set_ce(1'b0);
    wait_mode(3'h2, 3);
    rmc_host_model_i.config_bits(1'b1, 1'b1, 2'h1);
    rmc_host_model_i.set_ce(1'b1);
    wait_mode(3'h7, 3600);
    chk("rx active", 3'h1, {2'h0, rx_active_o});
    rx_pkt(3'h6, 2'h2);
    rx_pkt(3'h4, 2'h0);
    rx_pkt(3'h2, 2'h0);
    rx_pkt(3'h7, 2'h1);
    rpd_drive(1'b1, 900);
    chk("rpd early", 3'h0, {2'h0, received_power_flag_o});
    rpd_drive(1'b0, 1);
    rpd_drive(1'b1, 900);
    chk("rpd restart", 3'h0, {2'h0, received_power_flag_o});
    rpd_drive(1'b1, 200);
    chk("rpd set", 3'h1, {2'h0, received_power_flag_o});
    chk("rx held", 3'h7, mode_o);
    rpd_drive(1'b0, 1);
    rmc_host_model_i.set_ce(1'b0);
    wait_mode(3'h2, 3);
    chk("rate kept", 3'h1, {1'b0, air_rate_o});
    rmc_host_model_i.config_bits(1'b0, 1'b1, 2'h1);
    wait_mode(3'h0, 3);
    chk("rate in pd", 3'h1, {1'b0, air_rate_o});
    complete_run();
  end
endmodule // test_radio_mode_controller
`default_nettype wire
